// ---- design/serdes_bypass_pkg.sv ----
/*
  Shared constants and types for the bypass serializer/deserializer path.
  Assumes a single 200 MHz ref_clk domain and eight byte-wide channels.
*/
package serdes_bypass_pkg;

  // ==========================================================
  // Channel geometry
  localparam int NUM_CH = 8;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // Clocking and link limits
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_MIN_KHZ = 63000;
  localparam int REF_MAX_KHZ = 106250;
  localparam int LINE_MAX_KBPS = 850000;

  // ==========================================================
  // Rate select encoding, one field per channel
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;

  // Bits per word in each rate
  localparam logic [3:0] BITS_FULL = 4'h8;
  localparam logic [3:0] BITS_HALF = 4'h4;
  localparam logic [3:0] BITS_QUARTER = 4'h2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } tx_word_t;

  typedef struct packed {
    logic valid;
    logic recClk;
    logic [BYTE_W-1:0] data;
  } rx_word_t;

  // Reserved code behaves as full rate
  function automatic logic [3:0] bitsFor(input logic [1:0] rate);
    logic [3:0] n;
    n = BITS_FULL;
    if (rate == RATE_HALF) begin
      n = BITS_HALF;
    end else if (rate == RATE_QUARTER) begin
      n = BITS_QUARTER;
    end
    return n;
  endfunction

endpackage

// ---- design/serdes_bypass_rate_path.sv ----
/*
  Bypass serializer/deserializer path, eight full-duplex channels.
  Assumes fabric-side inputs synchronous to ref_clk, a recovered-bit
  strobe from the clock recovery front end, and scrambled line data.
*/
`timescale 1ns/1ps

// Function
// - In bypass mode data passes only through serializer and deserializer, no framing or scrambling.
// - The transmit path serializes each fabric word and drives it onto the differential line unchanged.
// - The receive path deserializes the line and hands words to the fabric with the recovered clock.
// - Half rate runs the serializer at four times the reference and uses only bits 7 to 4.
// - Quarter rate runs the serializer at twice the reference and uses only bits 7 to 6.
// - Each channel has its own rate setting so that mixed rates run together.
// - Reference clocks from 63.00 MHz to 106.25 MHz are supported in all three rates.
// - Any bandwidth inside the reference limits is supported, gaps between rates are allowed.
// - Receive logic is timed by the recovered clock, which goes to the fabric for its crossing; here it runs on ref_clk, gated by rxBitStb.
// - Eight independent full-duplex channels are provided, each up to 850 Mbits/s.
module serdes_bypass_rate_path (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Mode and per-channel rate
  input wire logic bypassEn,
  input wire logic [serdes_bypass_pkg::NUM_CH-1:0][1:0] rateSel,
  // Fabric transmit words
  input wire serdes_bypass_pkg::tx_word_t [serdes_bypass_pkg::NUM_CH-1:0] txIn,
  output logic [serdes_bypass_pkg::NUM_CH-1:0] txReady,
  // Serial transmit line
  output logic [serdes_bypass_pkg::NUM_CH-1:0] txLineP,
  output logic [serdes_bypass_pkg::NUM_CH-1:0] txLineN,
  // Serial receive line
  input wire logic [serdes_bypass_pkg::NUM_CH-1:0] rxLineP,
  input wire logic [serdes_bypass_pkg::NUM_CH-1:0] rxLineN,
  input wire logic [serdes_bypass_pkg::NUM_CH-1:0] rxBitStb,
  // Fabric receive words
  output serdes_bypass_pkg::rx_word_t [serdes_bypass_pkg::NUM_CH-1:0] rxOut
);

  typedef enum logic {CH_IDLE, CH_SHIFT} ch_state_t;

  typedef struct packed {
    ch_state_t st;
    logic [2:0] txCnt;
    logic [7:0] txSh;
    logic [1:0] txRate;
    logic txBit;
    logic [2:0] rxCnt;
    logic [7:0] rxSh;
    logic [1:0] rxRate;
    logic [7:0] rxData;
    logic rxValid;
    logic recClk;
  } chan_t;

  typedef struct packed {
    chan_t [serdes_bypass_pkg::NUM_CH-1:0] ch;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [serdes_bypass_pkg::NUM_CH-1:0] fifoValid;
  logic [serdes_bypass_pkg::NUM_CH-1:0][7:0] fifoData;
  logic [serdes_bypass_pkg::NUM_CH-1:0] ld;
  logic [serdes_bypass_pkg::NUM_CH-1:0] lastBit;

  // ==========================================================
  // Transmit buffers and line drivers
  // eight channels
  genvar gi;
  generate
    for (gi = 0; gi < serdes_bypass_pkg::NUM_CH; gi++) begin : g_ch
      // Absorbs fabric bursts while the serializer shifts at line speed
      tx_word_fifo #(
        .WIDTH(serdes_bypass_pkg::BYTE_W),
        .DEPTH(serdes_bypass_pkg::FIFO_DEPTH)
      ) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .inValid(txIn[gi].valid),
        .inData(txIn[gi].data),
        .inReady(txReady[gi]),
        .outValid(fifoValid[gi]),
        .outData(fifoData[gi]),
        .outReady(ld[gi])
      );

      assign txLineP[gi] = st_ff.ch[gi].txBit;
      assign txLineN[gi] = ~st_ff.ch[gi].txBit;

      assign rxOut[gi].valid = st_ff.ch[gi].rxValid;
      assign rxOut[gi].recClk = st_ff.ch[gi].recClk;
      assign rxOut[gi].data = st_ff.ch[gi].rxData;

      // ======================================================
      // Checks
      a_bypass_line_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        !bypassEn |=> !txLineP[gi])
        else $error("line driven outside bypass");

      a_tx_msb_first: assert property (@(posedge ref_clk) disable iff (!nrst)
        ld[gi] |=> (txLineP[gi] == $past(fifoData[gi][7])))
        else $error("first serial bit is not bit 7");

      a_tx_line_diff: assert property (@(posedge ref_clk) disable iff (!nrst)
        ld[gi] |=> (txLineN[gi] != txLineP[gi]) [*2])
        else $error("line pair not complementary");

      a_full_word_span: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ld[gi] && (rateSel[gi] != serdes_bypass_pkg::RATE_HALF)
          && (rateSel[gi] != serdes_bypass_pkg::RATE_QUARTER) && bypassEn)
        ##1 bypassEn [*8] |-> $past(lastBit[gi]) == 1'b0 && lastBit[gi])
        else $error("full rate word is not eight bits");

      a_half_word_span: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ld[gi] && rateSel[gi] == serdes_bypass_pkg::RATE_HALF)
        |=> (!ld[gi]) [*3] ##1 (lastBit[gi] || !bypassEn))
        else $error("half rate word is not four bits");

      a_quarter_word_span: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ld[gi] && rateSel[gi] == serdes_bypass_pkg::RATE_QUARTER && bypassEn)
        ##1 bypassEn |-> $past(ld[gi]) && !ld[gi] ##1 (lastBit[gi] || !bypassEn))
        else $error("quarter rate word is not two bits");

      a_rx_half_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_ff.ch[gi].rxValid && st_ff.ch[gi].rxRate == serdes_bypass_pkg::RATE_HALF)
        |-> (st_ff.ch[gi].rxData[3:0] == 4'h0))
        else $error("half rate word has data below bit 4");

      a_rx_quarter_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_ff.ch[gi].rxValid && st_ff.ch[gi].rxRate == serdes_bypass_pkg::RATE_QUARTER)
        |-> (st_ff.ch[gi].rxData[5:0] == 6'h00))
        else $error("quarter rate word has data below bit 6");

      a_rec_clk_word: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(st_ff.ch[gi].recClk) |-> st_ff.ch[gi].rxValid)
        else $error("recovered clock edge without a word");

      a_rx_word_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_ff.ch[gi].rxValid && bypassEn) |=> !st_ff.ch[gi].rxValid)
        else $error("word strobe longer than one cycle");

      // ======================================================
      // Serializer and deserializer bookkeeping
      a_tx_idle_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        (lastBit[gi] && !ld[gi]) |=> !txLineP[gi])
        else $error("line not low after last bit");

      a_tx_next_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        (bypassEn && (st_ff.ch[gi].st == CH_SHIFT) && !lastBit[gi])
        |=> (txLineP[gi] == $past(st_ff.ch[gi].txSh[7])))
        else $error("serial bit out of order");

      a_tx_word_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (bypassEn && fifoValid[gi] && (st_ff.ch[gi].st == CH_IDLE)) |-> ld[gi])
        else $error("idle serializer left a word queued");

      a_tx_rate_held: assert property (@(posedge ref_clk) disable iff (!nrst)
        (bypassEn && (st_ff.ch[gi].st == CH_SHIFT) && !ld[gi])
        |=> (st_ff.ch[gi].txRate == $past(st_ff.ch[gi].txRate)))
        else $error("rate changed inside a word");

      a_tx_cnt_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_ff.ch[gi].st == CH_SHIFT)
        |-> ({1'b0, st_ff.ch[gi].txCnt} < serdes_bypass_pkg::bitsFor(st_ff.ch[gi].txRate)))
        else $error("bit count beyond word width");

      a_rx_off_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        !bypassEn |=> (!st_ff.ch[gi].rxValid && !st_ff.ch[gi].recClk
          && (st_ff.ch[gi].rxCnt == 3'h0)))
        else $error("receive state kept outside bypass");

      a_rx_bad_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
        (bypassEn && rxBitStb[gi] && (rxLineP[gi] == rxLineN[gi]))
        |=> (st_ff.ch[gi].rxCnt == $past(st_ff.ch[gi].rxCnt)))
        else $error("bit taken from an invalid pair");

      a_rx_no_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
        (bypassEn && !rxBitStb[gi]) |=> $stable(st_ff.ch[gi].rxSh))
        else $error("bit taken without recovered strobe");

      a_rx_cnt_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_ff.ch[gi].rxCnt != 3'h0)
        |-> ({1'b0, st_ff.ch[gi].rxCnt} < serdes_bypass_pkg::bitsFor(st_ff.ch[gi].rxRate)))
        else $error("receive count beyond word width");

      a_rx_clk_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
        ($fell(st_ff.ch[gi].recClk) && bypassEn) |-> (st_ff.ch[gi].rxCnt != 3'h0))
        else $error("recovered clock fell outside a word");
    end
  endgenerate

  // ==========================================================
  // Per-channel next state
  always_comb begin
    logic [3:0] nb;
    logic [1:0] rr;
    logic [2:0] pos;
    logic [7:0] sh;
    logic bitIn;
    nb = serdes_bypass_pkg::BITS_FULL;
    rr = serdes_bypass_pkg::RATE_FULL;
    pos = serdes_bypass_pkg::CNT_RST;
    sh = serdes_bypass_pkg::BYTE_RST;
    bitIn = 1'b0;
    nxt_st = st_ff;
    ld = '0;
    lastBit = '0;
    for (int i = 0; i < serdes_bypass_pkg::NUM_CH; i++) begin
      lastBit[i] = (st_ff.ch[i].st == CH_SHIFT) && (st_ff.ch[i].txCnt == 3'h0);
      ld[i] = bypassEn && fifoValid[i] && ((st_ff.ch[i].st == CH_IDLE) || lastBit[i]);

      // ------------------------------------------------------
      // Transmit serializer
      if (!bypassEn) begin
        nxt_st.ch[i].st = CH_IDLE;
        nxt_st.ch[i].txBit = 1'b0;
        nxt_st.ch[i].txCnt = serdes_bypass_pkg::CNT_RST;
        nxt_st.ch[i].txSh = serdes_bypass_pkg::BYTE_RST;
      end else if (ld[i]) begin
        // rate taken per channel at word start
        // bit count depends on rate only, not on reference frequency
        // any reference inside the limits scales all three rates alike
        nb = serdes_bypass_pkg::bitsFor(rateSel[i]);
        nxt_st.ch[i].st = CH_SHIFT;
        nxt_st.ch[i].txRate = rateSel[i];
        nxt_st.ch[i].txCnt = 3'(nb - 4'h1);
        // bit 7 leaves first, word unchanged
        nxt_st.ch[i].txBit = fifoData[i][7];
        nxt_st.ch[i].txSh = {fifoData[i][6:0], 1'b0};
      end else if (st_ff.ch[i].st == CH_SHIFT) begin
        if (lastBit[i]) begin
          // Idle line low; fabric scrambling keeps density up
          nxt_st.ch[i].st = CH_IDLE;
          nxt_st.ch[i].txBit = 1'b0;
        end else begin
          nxt_st.ch[i].txBit = st_ff.ch[i].txSh[7];
          nxt_st.ch[i].txSh = {st_ff.ch[i].txSh[6:0], 1'b0};
          nxt_st.ch[i].txCnt = 3'(st_ff.ch[i].txCnt - 3'h1);
        end
      end

      // ------------------------------------------------------
      // Receive deserializer
      nxt_st.ch[i].rxValid = 1'b0;
      if (!bypassEn) begin
        nxt_st.ch[i].rxCnt = serdes_bypass_pkg::CNT_RST;
        nxt_st.ch[i].rxSh = serdes_bypass_pkg::BYTE_RST;
        nxt_st.ch[i].recClk = 1'b0;
      end else if (rxBitStb[i] && (rxLineP[i] != rxLineN[i])) begin
        // timing follows recovered bit strobes only
        rr = (st_ff.ch[i].rxCnt == 3'h0) ? rateSel[i] : st_ff.ch[i].rxRate;
        nb = serdes_bypass_pkg::bitsFor(rr);
        bitIn = rxLineP[i];
        pos = 3'(3'h7 - st_ff.ch[i].rxCnt);
        sh = st_ff.ch[i].rxSh | (8'({7'h00, bitIn}) << pos);
        nxt_st.ch[i].rxRate = rr;
        if ({1'b0, st_ff.ch[i].rxCnt} == 4'(nb - 4'h1)) begin
          // word out, low unused bits zero
          nxt_st.ch[i].rxData = sh;
          nxt_st.ch[i].rxValid = 1'b1;
          // recovered word clock rises with each word
          nxt_st.ch[i].recClk = 1'b1;
          nxt_st.ch[i].rxCnt = serdes_bypass_pkg::CNT_RST;
          nxt_st.ch[i].rxSh = serdes_bypass_pkg::BYTE_RST;
        end else begin
          nxt_st.ch[i].rxCnt = 3'(st_ff.ch[i].rxCnt + 3'h1);
          nxt_st.ch[i].rxSh = sh;
          // Falls half way through the next word
          if ({1'b0, st_ff.ch[i].rxCnt} + 4'h1 == (nb >> 1)) begin
            nxt_st.ch[i].recClk = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ---- design/tx_word_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; the drain side may stall at will.
*/
`timescale 1ns/1ps
module tx_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic doWr;
  logic doRd;

  // ==========================================================
  // Handshake
  assign inReady = (st_ff.cnt != (AW+1)'(DEPTH));
  assign outValid = (st_ff.cnt != '0);
  assign outData = st_ff.mem[st_ff.rd];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    if (doWr) begin
      nxt_st.mem[st_ff.wr] = inData;
      nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : AW'(st_ff.wr + 1'b1);
    end
    if (doRd) begin
      nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : AW'(st_ff.rd + 1'b1);
    end
    if (doWr && !doRd) begin
      nxt_st.cnt = (AW+1)'(st_ff.cnt + 1'b1);
    end else if (doRd && !doWr) begin
      nxt_st.cnt = (AW+1)'(st_ff.cnt - 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Checks
  a_fifo_full_stall: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.cnt == (AW+1)'(DEPTH)) |-> !inReady)
    else $error("fifo accepts while full");

endmodule

// ---- tb/remote_xcvr_model.sv ----
/*
  Behavioural remote transceiver that feeds the device's receive lines.
  Assumes one ref_clk; it drives its outputs at the falling edge.
*/
`timescale 1ns/1ps
module remote_xcvr_model (
  // Clock
  input wire logic ref_clk,
  // Serial line toward the device
  output logic [serdes_bypass_pkg::NUM_CH-1:0] rxLineP,
  output logic [serdes_bypass_pkg::NUM_CH-1:0] rxLineN,
  output logic [serdes_bypass_pkg::NUM_CH-1:0] rxBitStb
);
  logic busy;
  logic idleBit;

  // ==========================================================
  // Idle line
  initial begin
    busy = 1'b0;
    idleBit = 1'b0;
    rxLineP = '0;
    rxLineN = '1;
    rxBitStb = '0;
  end

  // strobe only in frames
  // Toggling so a stale bit is never mistaken for data
  always @(negedge ref_clk) begin
    if (!busy) begin
      idleBit = ~idleBit;
      rxLineP = {serdes_bypass_pkg::NUM_CH{idleBit}};
      rxLineN = {serdes_bypass_pkg::NUM_CH{~idleBit}};
      rxBitStb = '0;
    end
  end

  // ==========================================================
  // One word, MSB first
  // bits with their strobe
  // Slow mode puts a strobe on an invalid pair before each bit
  task automatic sendWord(input int ch, input logic [7:0] d, input int nb, input bit slow);
    busy = 1'b1;
    for (int k = 0; k < nb; k++) begin
      if (slow) begin
        @(negedge ref_clk);
        rxBitStb[ch] = 1'b1;
        rxLineP[ch] = ~d[7-k];
        rxLineN[ch] = ~d[7-k];
      end
      @(negedge ref_clk);
      rxBitStb[ch] = 1'b1;
      rxLineP[ch] = d[7-k];
      rxLineN[ch] = ~d[7-k];
    end
    @(negedge ref_clk);
    rxBitStb[ch] = 1'b0;
    rxLineP[ch] = ~rxLineP[ch];
    @(posedge ref_clk);
    busy = 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the bypass path.
  Assumes a 200 MHz ref_clk and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic nrst;
  logic bypassEn;
  logic [serdes_bypass_pkg::NUM_CH-1:0][1:0] rateSel;
  serdes_bypass_pkg::tx_word_t [serdes_bypass_pkg::NUM_CH-1:0] txIn;
  logic [serdes_bypass_pkg::NUM_CH-1:0] txReady, txLineP, txLineN;
  logic [serdes_bypass_pkg::NUM_CH-1:0] rxLineP, rxLineN, rxBitStb;
  serdes_bypass_pkg::rx_word_t [serdes_bypass_pkg::NUM_CH-1:0] rxOut;
  int n_errors = 0;
  int num_checks = 0;

  // ==========================================================
  // Device and far side
  serdes_bypass_rate_path serdes_bypass_rate_path_i (.ref_clk(ref_clk), .nrst(nrst),
    .bypassEn(bypassEn), .rateSel(rateSel), .txIn(txIn), .txReady(txReady),
    .txLineP(txLineP), .txLineN(txLineN), .rxLineP(rxLineP), .rxLineN(rxLineN),
    .rxBitStb(rxBitStb), .rxOut(rxOut));
  remote_xcvr_model remote_xcvr_model_i (.ref_clk(ref_clk), .rxLineP(rxLineP),
    .rxLineN(rxLineN), .rxBitStb(rxBitStb));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Helpers
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  function automatic int nbits(input logic [1:0] r);
    return (r == 2'h1) ? 4 : (r == 2'h2) ? 2 : 8;
  endfunction

  task automatic close_out();
    $display("Counts: %0d checks, %0d errors", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    check(txLineP === 8'h00 && txLineN === 8'hFF, "tx line not idle in reset");
    check(rxOut === '0 && txReady === 8'hFF, "outputs not clear in reset");
    $display("test_reset done");
  endtask

  // All rate codes at once, one per channel
  task automatic test_tx_mixed();
    logic [7:0] d [8];
    logic e;
    @(negedge ref_clk);
    check(txReady === 8'hFF, "fifo not ready");
    for (int c = 0; c < 8; c++) begin
      d[c] = 8'hA5 + 8'(c * 8'h13);
      rateSel[c] = 2'(c);
      txIn[c] = '{valid: 1'b1, data: d[c]};
    end
    @(negedge ref_clk);
    for (int c = 0; c < 8; c++) txIn[c].valid = 1'b0;
    @(posedge ref_clk);
    for (int k = 0; k < 9; k++) begin
      @(negedge ref_clk);
      for (int c = 0; c < 8; c++) begin
        e = (k < nbits(2'(c))) ? d[c][7-k] : 1'b0;
        check(txLineP[c] === e && txLineN[c] === ~e, "tx serial bit");
      end
    end
    $display("test_tx_mixed done");
  endtask

  // Fill while stalled, refuse, then drain as one stream
  task automatic test_fifo_fill();
    logic [7:0] w [8];
    int t;
    rateSel = '0;
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk);
      bypassEn = 1'b0;
      check(txReady[0] === (i < 8), "fifo ready level");
      if (i < 8) w[i] = 8'hC5 ^ 8'(i);
      txIn[0] = '{valid: 1'b1, data: 8'hC5 ^ 8'(i)};
    end
    check(txLineP[0] === 1'b0 && txLineN[0] === 1'b1, "line not idle");
    @(negedge ref_clk);
    txIn[0].valid = 1'b0;
    bypassEn = 1'b1;
    t = 0;
    while (txLineP[0] !== 1'b1 && t < 10) begin
      @(negedge ref_clk);
      t++;
    end
    for (int j = 0; j < 64; j++) begin
      check(txLineP[0] === w[j/8][7-j%8], "stream bit");
      @(negedge ref_clk);
    end
    check(txLineP[0] === 1'b0 && txReady[0] === 1'b1, "not idle after drain");
    $display("test_fifo_fill done");
  endtask

  task automatic rx_word(input int c, input logic [7:0] d, input bit slow, input int nExp);
    int seen;
    int nb;
    seen = 0;
    nb = nbits(rateSel[c]);
    fork
      remote_xcvr_model_i.sendWord(c, d, nb, slow);
      repeat (40) begin
        @(negedge ref_clk);
        if (rxOut[c].valid === 1'b1) begin
          seen++;
          check(rxOut[c].data === (d & 8'(8'hFF << (8 - nb))), "rx data");
          check(rxOut[c].recClk === 1'b1, "recovered clock low");
        end
      end
    join
    check(seen == nExp, "rx word count");
  endtask

  // Every channel, prompt and slow strobes, then bypass off
  task automatic test_rx();
    for (int c = 0; c < 8; c++) begin
      @(negedge ref_clk);
      rateSel[c] = 2'(c % 3);
      rx_word(c, 8'h5A ^ 8'(c * 8'h21), c[0], 1);
    end
    @(negedge ref_clk);
    bypassEn = 1'b0;
    rx_word(0, 8'h96, 1'b0, 0);
    check(rxOut[0].recClk === 1'b0, "recovered clock kept");
    $display("test_rx done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    bypassEn = 1'b0;
    rateSel = '0;
    txIn = '0;
    repeat (8) @(negedge ref_clk);
    test_reset();
    nrst = 1'b1;
    bypassEn = 1'b1;
    test_tx_mixed();
    test_fifo_fill();
    bypassEn = 1'b1;
    test_rx();
    close_out();
  end

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
